// ---- bwt_pkg.sv ----
// Constants for the board watchdog timer: I/O map, fields, resets, timing.
// Assumes a 50 MHz board logic clock and byte-wide I/O accesses.
package bwt_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int CODE_W = 4;
  localparam int CNT_W = 19;

  // I/O locations
  localparam logic [15:0] ADDR_RETRIGGER = 16'h0280;
  localparam logic [15:0] ADDR_TIMEOUT_CFG = 16'h0282;
  localparam logic [15:0] ADDR_ROUTING = 16'h0284;
  localparam logic [15:0] ADDR_STATUS = 16'h0286;

  // Field positions
  localparam int CFG_CODE_LSB = 0;
  localparam int CFG_ENABLE_BIT = 4;
  localparam int ROUTE_MGMT_BIT = 0;
  localparam int ROUTE_LINE5_BIT = 1;
  localparam int ROUTE_RESET_BIT = 2;
  localparam int ROUTE_W = 3;
  localparam int STATUS_WDT_BIT = 7;

  // Values after reset, unmapped read data and top timeout code
  localparam logic ENABLE_RESET = 1'h0;
  localparam logic [3:0] CODE_RESET = 4'h0;
  localparam logic [2:0] ROUTE_RESET = 3'h0;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  localparam logic [3:0] CODE_MAX = 4'hB;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int MIN_TIMEOUT_MS = 125;
  localparam int NOMINAL_PCT = 120;
  localparam int TICK_MS = TICK_NS / 1000000;
  localparam int MIN_BASE_TICKS = MIN_TIMEOUT_MS / TICK_MS;
  localparam int NOMINAL_BASE_TICKS =
    (MIN_TIMEOUT_MS * NOMINAL_PCT) / (100 * TICK_MS);

endpackage

// ---- bwt_tmr_if.sv ----
// Link between register front end and timeout counter.
// Assumes both ends share the board logic clock.
`timescale 1ns/1ns
interface bwt_tmr_if;
  logic restart;
  logic run;
  logic [3:0] code;
  logic expired;
  logic [18:0] ticks;

  modport ctl
  (
    output restart,
    output run,
    output code,
    input expired,
    input ticks
  );
  modport tmr
  (
    input restart,
    input run,
    input code,
    output expired,
    output ticks
  );
endinterface

// ---- bwt_timer.sv ----
// Timeout counter: millisecond prescaler and scaled tick counter.
// Assumes restart is a one-cycle pulse and run a steady level.
`timescale 1ns/1ns
module bwt_timer
#(
  parameter int TICK_CYCLES = bwt_pkg::TICK_CYCLES
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  bwt_tmr_if.tmr tif
);

  localparam int PRE_W = $clog2(TICK_CYCLES) + 1;
  localparam int CW = bwt_pkg::CNT_W;

  // Base period scaled by the code; reserved codes act as the top code
  function automatic logic [18:0] scaled(input int base,
                                         input logic [3:0] c);
    logic [3:0] s;
    s = (c > bwt_pkg::CODE_MAX) ? bwt_pkg::CODE_MAX : c;
    return CW'(base) << s;
  endfunction

  logic [PRE_W-1:0] pre;
  logic [CW-1:0] ticks;
  logic [3:0] code_act;
  logic expired;

  wire tick = (pre == PRE_W'(TICK_CYCLES - 1));
  wire hold = tif.restart || !tif.run;
  wire [CW-1:0] limit = scaled(bwt_pkg::NOMINAL_BASE_TICKS, code_act);
  wire [CW-1:0] min_limit = scaled(bwt_pkg::MIN_BASE_TICKS, code_act);
  wire reach = !hold && tick && (ticks == limit - CW'(1));

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pre <= '0;
    else if (hold || tick)
      pre <= '0;
    else
      pre <= pre + PRE_W'(1);
  end

  // RULE5: restart from zero
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      ticks <= '0;
    else if (hold)
      ticks <= '0;
    else if (tick && ticks != limit)
      ticks <= ticks + CW'(1);
  end

  // RULE12: code taken at restart
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      code_act <= bwt_pkg::CODE_RESET;
    else if (tif.restart)
      code_act <= tif.code;
  end

  // RULE7: fire at nominal period
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      expired <= 1'b0;
    else
      expired <= reach;
  end

  assign tif.expired = expired;
  assign tif.ticks = ticks;

  a_restart_clears: assert property ( // RULE5
    @(posedge clk_in) disable iff (!rst_n_in)
    tif.restart |=> (ticks == '0))
    else $error("Counter not cleared by restart");

  a_expiry_window: assert property ( // RULE7
    @(posedge clk_in) disable iff (!rst_n_in)
    expired |-> (ticks >= min_limit) && (ticks == limit))
    else $error("Expiry outside minimum to nominal window");

  a_code_scaling: assert property ( // RULE6
    @(posedge clk_in) disable iff (!rst_n_in)
    (code_act == 4'h0) |-> (limit == CW'(150)))
    else $error("Code zero does not give 150 ms nominal");

endmodule

// ---- bwt_watchdog.sv ----
// Board watchdog timer top: I/O register front end and expiry routing.
// Assumes one-cycle I/O strobes synchronous to clk_in, 50 MHz clock.
//
// Behaviour
// RULE1: One watchdog, timeout 125 ms to 256 s
// RULE2: Expiry gives reset or interrupts per routing
// RULE3: Config bit 4 enables; resets to zero
// RULE4: Enable cannot be cleared until system reset
// RULE5: Any write to 0x280 restarts timeout
// RULE6: Code 0..11 doubles 125 ms upward
// RULE7: Nominal timeout twenty percent above minimum
// RULE8: Host must retrigger within selected period
// RULE9: Config bits 7-5 reserved, read zero
// RULE10: Routing bits: reset, line five, management; reset zero
// RULE11: Expiry clears status bit 7, lights lamp
// RULE12: Enable starts from zero; code at retrigger
`timescale 1ns/1ns
module bwt_watchdog
#(
  parameter int TICK_CYCLES = bwt_pkg::TICK_CYCLES
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [15:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  output logic [7:0] io_rdata_out,
  output logic sys_reset_req_out,
  output logic system_mgmt_interrupt_out,
  output logic legacy_interrupt_line_five_out,
  output logic watchdog_indicator_lamp_out
);

  logic rst_meta;
  logic rst_n;

  // Reset release through two flops
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  logic enable;
  logic [3:0] code;
  logic [2:0] route;
  logic fired;

  bwt_tmr_if tif();

  // Address decode
  wire wr_trig = io_wr_in && (io_addr_in == bwt_pkg::ADDR_RETRIGGER);
  wire wr_cfg = io_wr_in && (io_addr_in == bwt_pkg::ADDR_TIMEOUT_CFG);
  wire wr_route = io_wr_in && (io_addr_in == bwt_pkg::ADDR_ROUTING);
  wire sel_cfg = (io_addr_in == bwt_pkg::ADDR_TIMEOUT_CFG);
  wire sel_route = (io_addr_in == bwt_pkg::ADDR_ROUTING);
  wire sel_status = (io_addr_in == bwt_pkg::ADDR_STATUS);
  wire en_write = wr_cfg && io_wdata_in[bwt_pkg::CFG_ENABLE_BIT];
  wire en_rise = en_write && !enable;

  // RULE9: reserved bits read zero
  wire [7:0] cfg_view = {3'h0, enable, code};
  wire [7:0] route_view = {5'h00, route};
  wire [7:0] status_view = {!fired, 7'h00};
  wire [7:0] rd_mux = sel_cfg ? cfg_view :
                      sel_route ? route_view :
                      sel_status ? status_view :
                      bwt_pkg::UNMAPPED_DATA;

  // RULE12: enable or retrigger restarts
  assign tif.restart = wr_trig || en_rise;
  assign tif.run = enable || en_rise;
  assign tif.code = en_write ?
    io_wdata_in[bwt_pkg::CFG_CODE_LSB +: bwt_pkg::CODE_W] : code;

  // RULE1: single programmable timer
  bwt_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer
  (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .tif(tif)
  );

  // RULE3: enable set by bit 4
  // RULE4: zero writes ignored
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      enable <= bwt_pkg::ENABLE_RESET;
    else if (en_write)
      enable <= 1'b1;
  end

  // RULE6: timeout code field
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      code <= bwt_pkg::CODE_RESET;
    else if (wr_cfg)
      code <= io_wdata_in[bwt_pkg::CFG_CODE_LSB +: bwt_pkg::CODE_W];
  end

  // RULE10: routing register
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      route <= bwt_pkg::ROUTE_RESET;
    else if (wr_route)
      route <= io_wdata_in[bwt_pkg::ROUTE_W-1:0];
  end

  // RULE11: expiry latched; set beats retrigger clear
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      fired <= 1'b0;
    else if (tif.expired)
      fired <= 1'b1;
    else if (wr_trig)
      fired <= 1'b0;
  end

  // RULE2: routed expiry outputs
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sys_reset_req_out <= 1'b0;
      system_mgmt_interrupt_out <= 1'b0;
      legacy_interrupt_line_five_out <= 1'b0;
      watchdog_indicator_lamp_out <= 1'b0;
    end
    else
    begin
      sys_reset_req_out <= fired && route[bwt_pkg::ROUTE_RESET_BIT];
      system_mgmt_interrupt_out <= fired && route[bwt_pkg::ROUTE_MGMT_BIT];
      legacy_interrupt_line_five_out <=
        fired && route[bwt_pkg::ROUTE_LINE5_BIT];
      watchdog_indicator_lamp_out <= fired;
    end
  end

  // Read data captured on the read strobe
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      io_rdata_out <= bwt_pkg::RDATA_RESET;
    else if (io_rd_in)
      io_rdata_out <= rd_mux;
  end

  a_enable_set: assert property ( // RULE3
    @(posedge clk_in) disable iff (!rst_n)
    en_write |=> enable)
    else $error("Enable bit not set by write of one");

  a_enable_sticky: assert property ( // RULE4
    @(posedge clk_in) disable iff (!rst_n)
    enable |=> enable)
    else $error("Enable bit cleared before reset");

  a_trigger_restart: assert property ( // RULE5
    @(posedge clk_in) disable iff (!rst_n)
    wr_trig && enable && !tif.expired
    |=> (tif.ticks == 19'h00000) && !fired)
    else $error("Retrigger write did not restart timeout");

  a_reset_route: assert property ( // RULE2
    @(posedge clk_in) disable iff (!rst_n)
    tif.expired && route[bwt_pkg::ROUTE_RESET_BIT] && !wr_route
    |=> ##1 sys_reset_req_out)
    else $error("Expiry did not raise routed reset");

  a_intr_route: assert property ( // RULE10
    @(posedge clk_in) disable iff (!rst_n)
    $rose(fired) |=> legacy_interrupt_line_five_out ==
      $past(route[bwt_pkg::ROUTE_LINE5_BIT]) &&
      system_mgmt_interrupt_out == $past(route[bwt_pkg::ROUTE_MGMT_BIT]))
    else $error("Interrupt outputs disagree with routing");

  a_status_lamp: assert property ( // RULE11
    @(posedge clk_in) disable iff (!rst_n)
    fired && sel_status && io_rd_in
    |=> watchdog_indicator_lamp_out && !io_rdata_out[7])
    else $error("Expiry not shown in status and lamp");

  a_expiry_latched: assert property ( // RULE11
    @(posedge clk_in) disable iff (!rst_n)
    tif.expired |=> fired)
    else $error("Expiry not latched");

  a_lamp_follows: assert property ( // RULE11
    @(posedge clk_in) disable iff (!rst_n)
    fired |=> watchdog_indicator_lamp_out)
    else $error("Lamp not lit after expiry");

  a_route_write: assert property ( // RULE10
    @(posedge clk_in) disable iff (!rst_n)
    wr_route |=> route == $past(io_wdata_in[2:0]))
    else $error("Routing write not stored");

  a_code_write: assert property ( // RULE6
    @(posedge clk_in) disable iff (!rst_n)
    wr_cfg |=> code == $past(io_wdata_in[3:0]))
    else $error("Timeout code write not stored");

  a_cfg_reserved: assert property ( // RULE9
    @(posedge clk_in) disable iff (!rst_n)
    io_rd_in && sel_cfg |=> io_rdata_out[7:5] == 3'h0)
    else $error("Reserved config bits read non-zero");

  a_disabled_quiet: assert property ( // RULE1
    @(posedge clk_in) disable iff (!rst_n)
    !enable && !en_rise |=> !tif.expired)
    else $error("Timer expired while disabled");

endmodule

// ---- board_watchdog_timer_test.sv ----
// Self-checking bench for the board watchdog timer top.
// Assumes bwt_pkg and the design files are compiled first.
`timescale 1ns/1ns
module board_watchdog_timer_test;
  localparam int TC = 10;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [15:0] io_addr_in = 16'h0000;
  logic [7:0] io_wdata_in = 8'h00;
  logic io_wr_in = 1'b0;
  logic io_rd_in = 1'b0;
  logic [7:0] io_rdata_out;
  logic sys_reset_req_out;
  logic system_mgmt_interrupt_out;
  logic legacy_interrupt_line_five_out;
  logic watchdog_indicator_lamp_out;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  wire [2:0] evt = {sys_reset_req_out, legacy_interrupt_line_five_out,
    system_mgmt_interrupt_out};

  bwt_watchdog #(.TICK_CYCLES(TC)) u_dut
  (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .io_addr_in(io_addr_in),
    .io_wdata_in(io_wdata_in),
    .io_wr_in(io_wr_in),
    .io_rd_in(io_rd_in),
    .io_rdata_out(io_rdata_out),
    .sys_reset_req_out(sys_reset_req_out),
    .system_mgmt_interrupt_out(system_mgmt_interrupt_out),
    .legacy_interrupt_line_five_out(legacy_interrupt_line_five_out),
    .watchdog_indicator_lamp_out(watchdog_indicator_lamp_out)
  );

  initial
  begin
    forever #10 clk_in = ~clk_in;
  end

  task automatic stop_test;
    if (fail_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fail_count++;
      $display("Error %0t: run too long", $time);
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    io_addr_in <= a;
    io_wdata_in <= d;
    io_wr_in <= 1'b1;
    @(posedge clk_in);
    io_wr_in <= 1'b0;
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    io_addr_in <= a;
    io_rd_in <= 1'b1;
    @(posedge clk_in);
    io_rd_in <= 1'b0;
    @(posedge clk_in);
    #1;
    chk(io_rdata_out, exp);
  endtask

  // Expiry time window and event routing
  task automatic expire(input int code, input logic [2:0] route);
    int n;
    n = 4;
    repeat (4) @(posedge clk_in);
    #1;
    while (watchdog_indicator_lamp_out !== 1'b1 && n < (200 * TC << code))
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check_count++;
    if (n < (125 * TC << code) || n > (150 * TC << code) + 4)
    begin
      fail_count++;
      $display("Error %0t: expiry after %0d cycles", $time, n);
    end
    chk({5'h00, evt}, {5'h00, route});
    rchk(bwt_pkg::ADDR_STATUS, 8'h00);
  endtask

  task automatic t_reset;
    rchk(bwt_pkg::ADDR_TIMEOUT_CFG, 8'h00);
    rchk(bwt_pkg::ADDR_ROUTING, 8'h00);
    rchk(bwt_pkg::ADDR_STATUS, 8'h80);
    rchk(bwt_pkg::ADDR_RETRIGGER, 8'h00);
    rchk(16'h0288, 8'h00);
    chk({4'h0, watchdog_indicator_lamp_out, evt}, 8'h00);
  endtask

  task automatic t_regs;
    wr(bwt_pkg::ADDR_ROUTING, 8'hFF);
    rchk(bwt_pkg::ADDR_ROUTING, 8'h07);
    wr(bwt_pkg::ADDR_TIMEOUT_CFG, 8'hEF);
    rchk(bwt_pkg::ADDR_TIMEOUT_CFG, 8'h0F);
    wr(bwt_pkg::ADDR_RETRIGGER, 8'h00);
    repeat (2000) @(posedge clk_in);
    #1;
    chk({7'h00, watchdog_indicator_lamp_out}, 8'h00);
  endtask

  task automatic t_lock;
    wr(bwt_pkg::ADDR_TIMEOUT_CFG, 8'h10);
    expire(0, 3'h7);
    wr(bwt_pkg::ADDR_TIMEOUT_CFG, 8'h01);
    rchk(bwt_pkg::ADDR_TIMEOUT_CFG, 8'h11);
    chk({7'h00, watchdog_indicator_lamp_out}, 8'h01);
    wr(bwt_pkg::ADDR_RETRIGGER, 8'hA5);
    rchk(bwt_pkg::ADDR_STATUS, 8'h80);
    chk({4'h0, watchdog_indicator_lamp_out, evt}, 8'h00);
    expire(1, 3'h7);
  endtask

  task automatic t_keep;
    wr(bwt_pkg::ADDR_TIMEOUT_CFG, 8'h1C);
    rchk(bwt_pkg::ADDR_TIMEOUT_CFG, 8'h1C);
    wr(bwt_pkg::ADDR_TIMEOUT_CFG, 8'h10);
    wr(bwt_pkg::ADDR_RETRIGGER, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      repeat (1000) @(posedge clk_in);
      wr(bwt_pkg::ADDR_RETRIGGER, 8'(i * 37));
      #1;
      chk({7'h00, watchdog_indicator_lamp_out}, 8'h00);
    end
  endtask

  task automatic t_route;
    logic [2:0] r;
    for (int i = 0; i < 3; i++)
    begin
      r = 3'(1 << i);
      wr(bwt_pkg::ADDR_ROUTING, {5'h00, r});
      wr(bwt_pkg::ADDR_RETRIGGER, 8'h3C);
      expire(0, r);
    end
  endtask

  task automatic t_rerst;
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_reset();
  endtask

  initial
  begin
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_reset();
    t_regs();
    t_lock();
    t_keep();
    t_route();
    t_rerst();
    stop_test();
  end
endmodule
